/* File: mac_model.sv */
// rmii transmit side of the mac
`timescale 1ns/1ps
module mac_model (
    input  wire       clk_i,
    input  wire       ref_clk_i,
    output reg  [1:0] txd_o,
    output reg        tx_en_o,
    output reg        tx_err_o
);
    initial begin
        txd_o = 2'b00;
        tx_en_o = 1'b0;
        tx_err_o = 1'b0;
    end
    // changed mid-period, away from the capturing rising edge
    task pair(input [1:0] d, input en, input err);
        begin
            @(negedge ref_clk_i);
            @(negedge clk_i);
            txd_o = d;
            tx_en_o = en;
            tx_err_o = err;
        end
    endtask
endmodule // mac_model

/* File: nibble_to_code.v */
// registered 4b/5b data table lookup
`timescale 1ns/1ps
`include "tx_enc_regs.vh"

module nibble_to_code (
    input  wire       clk_i,
    input  wire       nrst_i,
    input  wire [3:0] nibble_i,
    output reg  [4:0] code_o
);

// ----------------------------------------------------------------
// table
// ----------------------------------------------------------------
reg [4:0] code_d;

always @* begin
    case (nibble_i)
        4'h0: code_d = `CG_D0;
        4'h1: code_d = `CG_D1;
        4'h2: code_d = `CG_D2;
        4'h3: code_d = `CG_D3;
        4'h4: code_d = `CG_D4;
        4'h5: code_d = `CG_D5;
        4'h6: code_d = `CG_D6;
        4'h7: code_d = `CG_D7;
        4'h8: code_d = `CG_D8;
        4'h9: code_d = `CG_D9;
        4'hA: code_d = `CG_DA;
        4'hB: code_d = `CG_DB;
        4'hC: code_d = `CG_DC;
        4'hD: code_d = `CG_DD;
        4'hE: code_d = `CG_DE;
        default: code_d = `CG_DF;
    endcase
end

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        code_o <= `RST_CODE;
    end else begin
        code_o <= code_d;
    end
end

endmodule // nibble_to_code

/* File: rmii_tx_4b5b_encoder.v */
// rmii transmit front end: bit pairs to nibbles to 5-bit code-groups
//
// Function
// - txd and tx enable captured on each rising reference clock edge
// - two bits cross per 50 mhz reference clock cycle
// - bit pairs gathered into nibbles, each encoded to one 5-bit code-group
// - sixteen code-groups carry data, the other sixteen never do
// - idle and transmit error symbols distinct from all data codes
// - data nibbles use the fixed table, 0 to 11110 through f to 11101
// - tx enable rise sends j 11000 then k 10001 replacing first data
// - tx enable fall sends t 01101 then r 00111 after last data
// - transmit error rise on a data nibble after j and k sends code-group 00100
`timescale 1ns/1ps
`include "tx_enc_regs.vh"

module rmii_tx_4b5b_encoder (
    input  wire       clk_i,
    input  wire       nrst_i,
    input  wire       ref_clk_i,
    input  wire [1:0] txd_i,
    input  wire       tx_en_i,
    input  wire       tx_err_i,
    output reg  [4:0] code_o,
    output reg        code_valid_o
);

// ----------------------------------------------------------------
// pin synchronisers, three stages each
// ----------------------------------------------------------------
// ref clock is sampled, not used as a clock; all pins share one
// pipeline so data and enable stay aligned to the sampled edge
reg [2:0] clk_s_q;
reg [1:0] d0_s_q, d1_s_q, d2_s_q;
reg [2:0] en_s_q;
reg [2:0] er_s_q;

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        clk_s_q <= 3'h0;
        d0_s_q  <= 2'h0;
        d1_s_q  <= 2'h0;
        d2_s_q  <= 2'h0;
        en_s_q  <= 3'h0;
        er_s_q  <= 3'h0;
    end else begin
        clk_s_q <= {clk_s_q[1:0], ref_clk_i};
        d0_s_q  <= txd_i;
        d1_s_q  <= d0_s_q;
        d2_s_q  <= d1_s_q;
        en_s_q  <= {en_s_q[1:0], tx_en_i};
        er_s_q  <= {er_s_q[1:0], tx_err_i};
    end
end

// filtered ref clock level: changes once stages two and three agree
reg clk_f_q;
always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        clk_f_q <= 1'b0;
    end else if (clk_s_q[1] == clk_s_q[2]) begin
        clk_f_q <= clk_s_q[2];
    end
end

// one rising edge per ref clock cycle; limitation: this works only for
// a slow bench ref clock, a real 50 mhz one needs a faster core clock
wire ref_rise = (clk_s_q[1] == clk_s_q[2]) & clk_s_q[2] & ~clk_f_q;

// ----------------------------------------------------------------
// sampling on ref clock rise
// ----------------------------------------------------------------
reg       en_q, en_prev_q, er_q;
reg [1:0] txd_q;
reg       smp_q;

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        en_q  <= 1'b0;
        er_q  <= 1'b0;
        txd_q <= 2'h0;
        smp_q <= 1'b0;
    end else begin
        smp_q <= ref_rise;
        if (ref_rise) begin
            en_q  <= en_s_q[2];
            er_q  <= er_s_q[2];
            txd_q <= d2_s_q;
        end
    end
end

// ----------------------------------------------------------------
// nibble assembly, low pair first
// ----------------------------------------------------------------
reg [1:0] lo_q;
reg       half_q;
reg [3:0] nib_q;
reg       nib_v_q;
reg       nib_er_q;

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        lo_q     <= 2'h0;
        half_q   <= 1'b0;
        nib_q    <= 4'h0;
        nib_v_q  <= 1'b0;
        nib_er_q <= 1'b0;
        en_prev_q <= 1'b0;
    end else begin
        nib_v_q <= 1'b0;
        if (smp_q) begin
            if (!en_q) begin
                half_q <= 1'b0;
            end else if (!half_q) begin
                lo_q   <= txd_q;
                half_q <= 1'b1;
            end else begin
                nib_q    <= {txd_q, lo_q};
                nib_er_q <= er_q;
                half_q   <= 1'b0;
                nib_v_q  <= 1'b1;
            end
            // an odd trailing pair is dropped at the fall of tx enable
            if (en_prev_q & ~en_q) begin
                nib_v_q <= 1'b1;
                nib_er_q <= 1'b0;
            end
            en_prev_q <= en_q;
        end
    end
end

// end marker travels with a pseudo nibble slot
reg end_q;
always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        end_q <= 1'b0;
    end else if (smp_q) begin
        end_q <= en_prev_q & ~en_q;
    end else begin
        end_q <= 1'b0;
    end
end

// ----------------------------------------------------------------
// data table, one cycle latency
// ----------------------------------------------------------------
wire [4:0] data_code;

nibble_to_code u_tab (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .nibble_i (nib_q),
    .code_o   (data_code)
);

reg slot_q, slot_end_q, slot_er_q;
always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        slot_q     <= 1'b0;
        slot_end_q <= 1'b0;
        slot_er_q  <= 1'b0;
    end else begin
        slot_q     <= nib_v_q;
        slot_end_q <= end_q;
        slot_er_q  <= nib_er_q;
    end
end

// ----------------------------------------------------------------
// stream state machine
// ----------------------------------------------------------------
localparam ST_IDLE = 3'd0;
localparam ST_K    = 3'd2;
localparam ST_DATA = 3'd3;
localparam ST_T    = 3'd4;
localparam ST_R    = 3'd5;

reg [2:0] st_q, st_d;
reg [4:0] code_d;
reg       er_prev_q;

always @* begin
    st_d   = st_q;
    code_d = code_o;
    if (slot_q) begin
        case (st_q)
            ST_IDLE: begin
                // a lone pair makes no nibble, so no frame to open
                if (!slot_end_q) begin
                    code_d = `CG_SSD_J;
                    st_d   = ST_K;
                end
            end
            ST_K: begin
                code_d = `CG_SSD_K;
                // one-nibble frame still closes, else next frame loses j
                st_d   = slot_end_q ? ST_T : ST_DATA;
            end
            ST_DATA: begin
                if (slot_end_q) begin
                    code_d = `CG_ESD_T;
                    st_d   = ST_R;
                end else if (slot_er_q & ~er_prev_q) begin
                    code_d = `CG_TX_ERR;
                end else begin
                    code_d = data_code;
                end
            end
            default: begin
                code_d = `CG_IDLE;
                st_d   = ST_IDLE;
            end
        endcase
    end else if (st_q == ST_T) begin
        code_d = `CG_ESD_T;
        st_d   = ST_R;
    end else if (st_q == ST_R) begin
        code_d = `CG_ESD_R;
        st_d   = ST_IDLE;
    end else if (st_q == ST_IDLE) begin
        code_d = `CG_IDLE;
    end
end

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        st_q         <= ST_IDLE;
        code_o       <= `RST_CODE;
        code_valid_o <= 1'b0;
        er_prev_q    <= 1'b0;
    end else begin
        st_q         <= st_d;
        code_o       <= code_d;
        code_valid_o <= (slot_q & ~(slot_end_q & (st_q == ST_IDLE)))
                        | (st_q == ST_T) | (st_q == ST_R);
        if (slot_q) begin
            er_prev_q <= slot_er_q;
        end
    end
end

endmodule // rmii_tx_4b5b_encoder

/* File: rmii_tx_4b5b_encoder_tb.sv */
// self-checking bench for the rmii transmit 4b/5b encoder
`timescale 1ns/1ps
module rmii_tx_4b5b_encoder_tb;
    reg        clk_i = 1'b0;
    reg        nrst_i = 1'b0;
    reg        ref_clk_i = 1'b0;
    wire [1:0] txd;
    wire       en;
    wire       err;
    wire [4:0] code_o;
    wire       code_valid_o;
    integer    mismatches = 0;
    integer    cmp_count = 0;
    integer    seed = 32'h2320;
    integer    i;
    integer    n;
    reg  [4:0] e;
    reg  [3:0] nib;
    reg  [4:0] exp_q[$];
    reg  [4:0] tbl[0:15] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
        5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C,
        5'h1D};
    initial forever #20 clk_i = ~clk_i;
    initial begin
        #7;
        forever #160 ref_clk_i = ~ref_clk_i;
    end
    mac_model mac (.clk_i(clk_i), .ref_clk_i(ref_clk_i), .txd_o(txd),
        .tx_en_o(en), .tx_err_o(err));
    rmii_tx_4b5b_encoder DUT (.clk_i(clk_i), .nrst_i(nrst_i),
        .ref_clk_i(ref_clk_i), .txd_i(txd), .tx_en_i(en), .tx_err_i(err),
        .code_o(code_o), .code_valid_o(code_valid_o));
    task check(input [4:0] x, input [4:0] s, input [8*10-1:0] nm);
        begin
            cmp_count = cmp_count + 1;
            if (s !== x) begin
                mismatches = mismatches + 1;
                $display("FAIL %0s expected %h seen %h", nm, x, s);
            end
        end
    endtask
    // ----
    // monitor: each symbol slot against the oldest note
    // ----
    always @(negedge clk_i) begin
        if (code_valid_o === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 5'h1F;
            check(e, code_o, "code_o");
        end
    end
    task frame(input integer len, input integer ea, input odd, input sq);
        begin
            exp_q.push_back(5'h18);
            exp_q.push_back(5'h11);
            for (i = 0; i < len; i = i + 1) begin
                nib = sq ? i - 2 : $random(seed);
                if (i >= 2) exp_q.push_back(i == ea ? 5'h04 : tbl[nib]);
                mac.pair(nib[1:0], 1'b1, i == ea);
                mac.pair(nib[3:2], 1'b1, i == ea);
            end
            if (odd) mac.pair(2'b11, 1'b1, 1'b0);
            exp_q.push_back(5'h0D);
            exp_q.push_back(5'h07);
            for (i = 0; i < 12; i = i + 1) mac.pair(~txd, 1'b0, 1'b0);
            check(5'h1F, code_o, "code_o");
            n = exp_q.size();
            check(5'h00, n[4:0], "notes_left");
            $display("test frame of %0d nibbles done", len);
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", cmp_count, mismatches);
            if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        repeat (16) @(negedge clk_i);
        check(5'h1F, code_o, "code_o");
        nrst_i = 1'b1;
        frame(18, 99, 1'b0, 1'b1);
        frame(5, 3, 1'b0, 1'b0);
        frame(4, 99, 1'b1, 1'b0);
        frame(3, 99, 1'b0, 1'b0);
        // reset again between frames, then the shortest frame
        @(negedge clk_i);
        nrst_i = 1'b0;
        repeat (2) @(negedge clk_i);
        check(5'h1F, code_o, "code_o");
        nrst_i = 1'b1;
        frame(1, 99, 1'b0, 1'b0);
        complete_run;
    end
    // frames need well under 60 us; a hang is cut after 200 us
    initial begin
        #200_000;
        mismatches = mismatches + 1;
        complete_run;
    end
endmodule // rmii_tx_4b5b_encoder_tb

/* File: tx_enc_checker.sv */
// assertions for the rmii transmit 4b/5b encoder
`timescale 1ns/1ps
module tx_enc_checker (
    input wire       clk_i,
    input wire       nrst_i,
    input wire       tx_en_i,
    input wire [4:0] code_o,
    input wire       code_valid_o
);
    reg [6:0] off_q;
    // saturates so a long idle gap never wraps back into a frame window
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) off_q <= 7'd0;
        else if (tx_en_i) off_q <= 7'd0;
        else if (off_q != 7'h7f) off_q <= off_q + 7'd1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // ----
    // code-group relations
    // ----
    chk_code_legal: assert property (
        code_valid_o |-> !(code_o inside {5'h00, 5'h01, 5'h02, 5'h03,
        5'h05, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h19, 5'h1F}))
        else $error("invalid or idle code-group marked valid");
    chk_start_j: assert property (
        $rose(tx_en_i) |-> ##[1:60] (code_valid_o && code_o == 5'h18))
        else $error("no start symbol after enable rise");
    chk_j_then_k: assert property (
        code_valid_o && code_o == 5'h18
        |-> ##[1:24] (code_valid_o && code_o == 5'h11))
        else $error("second start symbol missing");
    chk_t_then_r: assert property (
        code_valid_o && code_o == 5'h0D |=> code_valid_o && code_o == 5'h07)
        else $error("end symbol pair broken");
    chk_r_to_idle: assert property (
        code_valid_o && code_o == 5'h07 |-> ##[1:8] code_o == 5'h1F)
        else $error("no idle after end symbols");
    chk_idle_off: assert property (
        off_q >= 7'd64 |-> code_o == 5'h1F && !code_valid_o)
        else $error("not idle while enable low");
    chk_valid_en: assert property (
        code_valid_o |-> off_q < 7'd40)
        else $error("symbol slot without enable");
    chk_reset_idle: assert property (
        $rose(nrst_i) |-> code_o == 5'h1F && !code_valid_o)
        else $error("not idle out of reset");
    cov_err: cover property (code_valid_o && code_o == 5'h04);
    cov_end: cover property (code_valid_o && code_o == 5'h07);
    cov_start: cover property (code_valid_o && code_o == 5'h11);
endmodule // tx_enc_checker

bind rmii_tx_4b5b_encoder tx_enc_checker chk (.clk_i, .nrst_i, .tx_en_i,
    .code_o, .code_valid_o);

/* File: tx_enc_regs.vh */
// constants for the rmii transmit 4b/5b encoder
`ifndef TX_ENC_REGS_VH
`define TX_ENC_REGS_VH

// ----------------------------------------------------------------
// control code-groups
// ----------------------------------------------------------------
`define CG_IDLE      5'h1F
`define CG_SSD_J     5'h18
`define CG_SSD_K     5'h11
`define CG_ESD_T     5'h0D
`define CG_ESD_R     5'h07
`define CG_TX_ERR    5'h04

// ----------------------------------------------------------------
// data code-groups, nibble 0 to f
// ----------------------------------------------------------------
`define CG_D0        5'h1E
`define CG_D1        5'h09
`define CG_D2        5'h14
`define CG_D3        5'h15
`define CG_D4        5'h0A
`define CG_D5        5'h0B
`define CG_D6        5'h0E
`define CG_D7        5'h0F
`define CG_D8        5'h12
`define CG_D9        5'h13
`define CG_DA        5'h16
`define CG_DB        5'h17
`define CG_DC        5'h1A
`define CG_DD        5'h1B
`define CG_DE        5'h1C
`define CG_DF        5'h1D

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_CODE     5'h1F

`endif
